/* File: src/serdes_link.sv */
// What this block does
// - Frame word with start one, stop zero
// - Send eighteen bit times per word
// - Capture input word on word clock rise
// - Six cycles of sync request select sync
// - Sync word: eight ones, eight zeros
// - Serial output off until transmit PLL locks
// - Locked transmitter sends sync while requested
// - Receive outputs off until reference lock, lock high while locking
// - Lock after 150 clean sync words
// - Lock falls with first valid output word
// - Recovered clock aligned; data valid when locked
// - Two missed edges drop lock, research
// - No lock while multiple edges repeat
// - Low bit followed by high bit adds edge
// - Receive powerdown stops PLL, outputs off
// - Receive wakeup repeats whole lock procedure
// - Transmit powerdown tristates; relock on wakeup
// - Output enable gates all receive outputs
module serdes_link
	import serdes_pkg::*;
(
	input  wire logic        i_clk_sys,          // System clock, 100 MHz
	input  wire logic        i_rstn,             // Async reset, active low
	input  wire logic        i_hsel,             // AHB slave select
	input  wire logic [31:0] i_haddr,            // AHB address
	input  wire logic [1:0]  i_htrans,           // AHB transfer type
	input  wire logic        i_hwrite,           // AHB write
	input  wire logic [2:0]  i_hsize,            // AHB size, word only
	input  wire logic [31:0] i_hwdata,           // AHB write data
	input  wire logic        i_hready,           // AHB bus ready
	output logic      [31:0] o_hrdata,           // AHB read data
	output logic             o_hreadyout,        // AHB slave ready
	output logic             o_hresp,            // AHB response, OKAY
	input  wire logic        i_tx_word_clock,    // Transmit word clock pin
	input  wire logic [15:0] i_parallel_data_in, // Transmit word pins
	input  wire logic        i_sync_request,     // Sync request pin
	output logic             o_tx_serial,        // Serial line out
	output logic             o_tx_serial_oe,     // Serial line drive enable
	input  wire logic        i_rx_reference_clock, // Receive ref clock pin
	input  wire logic        i_rx_serial,        // Serial line in
	output logic      [15:0] o_parallel_data_out, // Recovered word
	output logic             o_parallel_data_oe, // Recovered word enable
	output logic             o_lock_status_n,    // Lock, active low
	output logic             o_lock_status_oe,   // Lock pin enable
	output logic             o_recovered_clock,  // Recovered word clock
	output logic             o_recovered_clk_oe  // Recovered clock enable
);

	tx_link_if link ();

	tx_framer u_framer (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.link      (link.framer)
	);

	// Pin synchronisers: first stage feeds only the second
	logic        tx_word_clock_s1, tx_word_clock_s2, tx_word_clock_s3;
	logic        rclk_s1, rclk_s2, rclk_s3;
	logic        sreq_s1, sreq_s2;
	logic        rx_s1, rx_s2, rx_prev;
	logic [15:0] din_s1, din_s2;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_word_clock_s1 <= 1'b0;
			tx_word_clock_s2 <= 1'b0;
			tx_word_clock_s3 <= 1'b0;
			rclk_s1 <= 1'b0;
			rclk_s2 <= 1'b0;
			rclk_s3 <= 1'b0;
			sreq_s1 <= 1'b0;
			sreq_s2 <= 1'b0;
			rx_s1   <= 1'b0;
			rx_s2   <= 1'b0;
			rx_prev <= 1'b0;
			din_s1  <= '0;
			din_s2  <= '0;
		end else begin
			tx_word_clock_s1 <= i_tx_word_clock;
			tx_word_clock_s2 <= tx_word_clock_s1;
			tx_word_clock_s3 <= tx_word_clock_s2;
			rclk_s1 <= i_rx_reference_clock;
			rclk_s2 <= rclk_s1;
			rclk_s3 <= rclk_s2;
			sreq_s1 <= i_sync_request;
			sreq_s2 <= sreq_s1;
			rx_s1   <= i_rx_serial;
			rx_s2   <= rx_s1;
			rx_prev <= rx_s2;
			din_s1  <= i_parallel_data_in;
			din_s2  <= din_s1;
		end
	end

	wire tx_word_clock_rise = tx_word_clock_s2 & ~tx_word_clock_s3;
	wire rclk_rise = rclk_s2 & ~rclk_s3;
	wire line_rise = rx_s2 & ~rx_prev;

	// Register bus slave, zero wait states
	logic [3:0] ctrl;
	logic       wr_pend;
	logic [7:0] wr_addr;

	wire        addr_phase = i_hsel & i_htrans[1] & i_hready;
	wire [7:0]  rd_addr    = i_haddr[7:0];
	wire        ctrl_wr    = wr_pend & (wr_addr == OFS_CTRL);
	wire        tx_pd_n    = ctrl[CTRL_TX_PD_N];
	wire        rx_pd_n    = ctrl[CTRL_RX_PD_N];
	wire        rx_oe_req  = ctrl[CTRL_RX_OE];
	wire        sync_req   = ctrl[CTRL_SYNC] | sreq_s2;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_pend     <= 1'b0;
			wr_addr     <= '0;
			ctrl        <= CTRL_RESET;
			o_hreadyout <= 1'b0;
			o_hresp     <= 1'b0;
		end else begin
			wr_pend     <= addr_phase & i_hwrite;
			wr_addr     <= rd_addr;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
			if (ctrl_wr) begin
				ctrl <= i_hwdata[3:0];
			end
		end
	end

	// Transmit side
	tx_state_t tx_state;
	logic [3:0] tx_pll_cnt;
	logic [2:0] sync_cnt;

	wire        tx_run        = (tx_state == TX_RUN);
	wire [2:0]  next_sync_cnt = !sync_req ? 3'h0 :
	                            (sync_cnt == SYNC_HOLD) ? SYNC_HOLD :
	                            sync_cnt + 3'h1;
	wire        sync_now      = (next_sync_cnt == SYNC_HOLD);

	assign link.load = tx_run & tx_word_clock_rise;
	assign link.word = sync_now ? SYNC_WORD : din_s2;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_state   <= TX_OFF;
			tx_pll_cnt <= '0;
			sync_cnt   <= '0;
		end else if (!tx_pd_n) begin
			tx_state   <= TX_OFF;
			sync_cnt   <= '0;
		end else begin
			unique case (tx_state)
				TX_OFF: begin
					tx_state   <= TX_PLL;
					tx_pll_cnt <= '0;
				end
				TX_PLL: begin
					if (tx_word_clock_rise) begin
						if (tx_pll_cnt == TX_PLL_EDGES - 4'h1) begin
							tx_state <= TX_RUN;
						end else begin
							tx_pll_cnt <= tx_pll_cnt + 4'h1;
						end
					end
				end
				TX_RUN: begin
					if (tx_word_clock_rise) begin
						sync_cnt <= next_sync_cnt;
					end
				end
			endcase
		end
	end

	// Line stays undriven until the PLL model has counted its edges
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_tx_serial    <= 1'b0;
			o_tx_serial_oe <= 1'b0;
		end else begin
			o_tx_serial    <= tx_run & tx_pd_n & link.serial;
			o_tx_serial_oe <= tx_run & tx_pd_n;
		end
	end

	// Receive side: pos is the frame slot of the bit now in rx_s2
	rx_state_t  rx_state;
	logic [3:0] rx_pll_cnt;
	logic [4:0] pos;
	logic       edge_hit;
	logic       multi_hit;
	logic [16:0] win;
	logic [7:0] good_cnt;
	logic       miss_once;
	logic       rmt_seen;

	wire [FRAME_W-1:0] frame = {win, rx_s2};
	wire        at_start   = (pos == 5'h00);
	wire        pos_end    = (pos == LAST_POS);
	wire        search_hit = (rx_state == RX_SEARCH) & line_rise;
	wire        tracking   = (rx_state == RX_TRACK) |
	                         (rx_state == RX_LOCKED);
	wire        frame_ok   = edge_hit & ~rx_s2;
	wire        last_good  = (good_cnt == RX_SYNC_WORDS - 8'h01);
	wire        rx_alive   = rx_pd_n & (rx_state != RX_OFF) &
	                         (rx_state != RX_REF);

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			win <= '0;
		end else begin
			win <= frame[16:0];
		end
	end

	// Slot tracking; any rise off the start slot and before the stop slot is an extra edge
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			pos       <= '0;
			edge_hit  <= 1'b0;
			multi_hit <= 1'b0;
		end else if (search_hit) begin
			pos       <= 5'h01;
			edge_hit  <= 1'b1;
			multi_hit <= 1'b0;
		end else if (pos_end | ~tracking) begin
			pos       <= '0;
			edge_hit  <= 1'b0;
			multi_hit <= 1'b0;
		end else begin
			pos       <= pos + 5'h01;
			edge_hit  <= edge_hit | (at_start & line_rise);
			multi_hit <= multi_hit | (~at_start & line_rise);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_state            <= RX_OFF;
			rx_pll_cnt          <= '0;
			good_cnt            <= '0;
			miss_once           <= 1'b0;
			rmt_seen            <= 1'b0;
			o_lock_status_n     <= 1'b1;
			o_parallel_data_out <= '0;
			o_recovered_clock   <= 1'b0;
		end else if (!rx_pd_n) begin
			rx_state          <= RX_OFF;
			o_lock_status_n   <= 1'b1;
			o_recovered_clock <= 1'b0;
		end else begin
			unique case (rx_state)
				RX_OFF: begin
					rx_state   <= RX_REF;
					rx_pll_cnt <= '0;
				end
				RX_REF: begin
					if (rclk_rise) begin
						if (rx_pll_cnt == RX_PLL_EDGES - 4'h1) begin
							rx_state <= RX_SEARCH;
						end else begin
							rx_pll_cnt <= rx_pll_cnt + 4'h1;
						end
					end
				end
				RX_SEARCH: begin
					good_cnt <= '0;
					if (line_rise) begin
						rx_state <= RX_TRACK;
					end
				end
				RX_TRACK: begin
					if (pos_end) begin
						if (!frame_ok) begin
							rx_state <= RX_SEARCH;
							rmt_seen <= 1'b0;
						end else if (multi_hit) begin
							good_cnt <= '0;
							rmt_seen <= 1'b1;
						end else if (last_good) begin
							rx_state            <= RX_LOCKED;
							rmt_seen            <= 1'b0;
							miss_once           <= 1'b0;
							o_lock_status_n     <= 1'b0;
							o_parallel_data_out <= frame[16:1];
							o_recovered_clock   <= 1'b1;
						end else begin
							good_cnt <= good_cnt + 8'h01;
						end
					end
				end
				RX_LOCKED: begin
					if (pos_end) begin
						o_parallel_data_out <= frame[16:1];
						o_recovered_clock   <= 1'b1;
						if (frame_ok) begin
							miss_once <= 1'b0;
						end else if (miss_once) begin
							rx_state          <= RX_SEARCH;
							o_lock_status_n   <= 1'b1;
							o_recovered_clock <= 1'b0;
						end else begin
							miss_once <= 1'b1;
						end
					end else if (pos == HALF_POS) begin
						o_recovered_clock <= 1'b0;
					end
				end
			endcase
		end
	end

	// Output enables follow the enable bit only once past reference lock
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_parallel_data_oe <= 1'b0;
			o_lock_status_oe   <= 1'b0;
			o_recovered_clk_oe <= 1'b0;
		end else begin
			o_parallel_data_oe <= rx_oe_req & rx_alive;
			o_lock_status_oe   <= rx_oe_req & rx_alive;
			o_recovered_clk_oe <= rx_oe_req & rx_alive;
		end
	end

	// Read data is registered in the address phase for the data phase
	wire [4:0]  status = {rmt_seen, rx_state == RX_LOCKED, rx_alive,
	                      tx_run, o_lock_status_n};
	wire [31:0] rd_val = (rd_addr == OFS_CTRL)   ? {28'h0000000, ctrl} :
	                     (rd_addr == OFS_STATUS) ? {27'h0000000, status} :
	                     (rd_addr == OFS_RXDATA) ?
	                         {16'h0000, o_parallel_data_out} : 32'h00000000;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_hrdata <= '0;
		end else if (addr_phase & ~i_hwrite) begin
			o_hrdata <= rd_val;
		end
	end

endmodule

/* File: include/serdes_pkg.sv */
package serdes_pkg;

	// Word and frame geometry
	localparam int          WORD_W    = 16;
	localparam int          FRAME_W   = 18;
	localparam logic [15:0] SYNC_WORD = 16'hFF00;
	localparam logic [4:0]  LAST_POS  = 5'h11;
	localparam logic [4:0]  HALF_POS  = 5'h08;

	// Cycle and edge counts
	localparam logic [2:0]  SYNC_HOLD     = 3'h6;
	localparam logic [7:0]  RX_SYNC_WORDS = 8'h96;
	localparam logic [3:0]  TX_PLL_EDGES  = 4'h8;
	localparam logic [3:0]  RX_PLL_EDGES  = 4'h8;

	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_STATUS = 8'h04;
	localparam logic [7:0]  OFS_RXDATA = 8'h08;

	// Control register fields and reset value
	localparam int          CTRL_TX_PD_N = 0;
	localparam int          CTRL_RX_PD_N = 1;
	localparam int          CTRL_RX_OE   = 2;
	localparam int          CTRL_SYNC    = 3;
	localparam logic [3:0]  CTRL_RESET   = 4'h7;

	typedef enum logic [2:0] {
		RX_OFF,
		RX_REF,
		RX_SEARCH,
		RX_TRACK,
		RX_LOCKED
	} rx_state_t;

	typedef enum logic [1:0] {
		TX_OFF,
		TX_PLL,
		TX_RUN
	} tx_state_t;

endpackage

/* File: include/tx_link_if.sv */
interface tx_link_if;
	logic        load;
	logic [15:0] word;
	logic        serial;

	modport ctrl   (output load, output word, input serial);
	modport framer (input load, input word, output serial);
endinterface

/* File: src/tx_framer.sv */
module tx_framer
	import serdes_pkg::*;
(
	input  wire logic i_clk_sys, // System clock
	input  wire logic i_rstn,    // Async reset, active low
	tx_link_if.framer link       // Word load and serial bit
);

	logic [FRAME_W-1:0] shreg;

	// Start bit first, payload MSB first, stop bit last; zeros shifted in
	// keep the line at the stop level between words
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			shreg <= '0;
		end else if (link.load) begin
			shreg <= {1'b1, link.word, 1'b0};
		end else begin
			shreg <= {shreg[FRAME_W-2:0], 1'b0};
		end
	end

	assign link.serial = shreg[FRAME_W-1];

endmodule

/* File: verif/serdes_link_checker.sv */
module serdes_link_checker (
	input wire logic        i_clk_sys,           // Clock
	input wire logic        i_rstn,              // Reset
	input wire logic        o_hreadyout,         // Ready
	input wire logic        o_hresp,             // Response
	input wire logic        o_tx_serial,         // Line out
	input wire logic        o_tx_serial_oe,      // Line enable
	input wire logic [15:0] o_parallel_data_out, // Word
	input wire logic        o_parallel_data_oe,  // Word enable
	input wire logic        o_lock_status_n,     // Lock
	input wire logic        o_lock_status_oe,    // Lock enable
	input wire logic        o_recovered_clock,   // Word clock
	input wire logic        o_recovered_clk_oe   // Clock enable
);
	timeunit 1ns;
	timeprecision 1ns;

	wire logic [2:0] oe_all;

	assign oe_all = {o_parallel_data_oe, o_lock_status_oe, o_recovered_clk_oe};

	default clocking dc @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);

	ready_high_a: assert property ($past(i_rstn) |-> o_hreadyout)
		else $error("slave not ready");
	okay_resp_a: assert property (!o_hresp)
		else $error("response not okay");
	line_quiet_a: assert property (!o_tx_serial_oe |-> !o_tx_serial)
		else $error("line active while off");
	oe_group_a: assert property (oe_all inside {3'h0, 3'h7})
		else $error("receive enables differ");
	lock_word_a: assert property ($fell(o_lock_status_n) |->
		$rose(o_recovered_clock))
		else $error("lock without word");
	unlock_idle_a: assert property (o_lock_status_n |->
		!o_recovered_clock)
		else $error("clock while unlocked");
	rclk_shape_a: assert property ($rose(o_recovered_clock) |->
		o_recovered_clock[*8] ##1 o_recovered_clock ##1 !o_recovered_clock)
		else $error("recovered clock shape");
	word_hold_a: assert property (!o_lock_status_n &&
		!$rose(o_recovered_clock) |-> $stable(o_parallel_data_out))
		else $error("word moved off clock");

	cover property ($fell(o_lock_status_n));
	cover property ($rose(o_lock_status_n));
	cover property ($rose(o_tx_serial_oe));
endmodule

bind serdes_link serdes_link_checker chk_i (.*);

/* File: verif/far_serdes.sv */
module far_serdes
	import serdes_pkg::*;
(
	input  wire logic        i_clk_sys, // Bit clock
	input  wire logic        i_rstn,    // Reset, active low
	input  wire logic        i_sync,    // Send sync words
	input  wire logic        i_mute,    // Drop embedded clock
	input  wire logic [15:0] i_word,    // Data word
	output logic             o_serial   // Serial line
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [4:0]  pos;
	logic [17:0] sh;
	wire  [15:0] next_word;
	wire  [17:0] next_frame;

	assign next_word  = i_sync ? SYNC_WORD : i_word;
	// Muting models a broken far end, not an idle one
	assign next_frame = i_mute ? 18'h0 : {1'h1, next_word, 1'h0};
	assign o_serial   = sh[17];

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			pos <= 5'h0;
			sh  <= 18'h0;
		end else if (pos == LAST_POS) begin
			pos <= 5'h0;
			sh  <= next_frame;
		end else begin
			pos <= pos + 5'h1;
			sh  <= {sh[16:0], 1'h0};
		end
	end
endmodule

/* File: verif/tb_serdes_link.sv */
module tb_serdes_link
	import serdes_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        i_clk_sys = 1'h0;
	logic        i_rstn = 1'h0;
	logic        i_hsel = 1'h0;
	logic [31:0] i_haddr = 32'h0;
	logic [1:0]  i_htrans = 2'h0;
	logic        i_hwrite = 1'h0;
	logic [2:0]  i_hsize = 3'h2;
	logic [31:0] i_hwdata = 32'h0;
	logic        i_tx_word_clock = 1'h0;
	logic [15:0] i_parallel_data_in = 16'h4B2D;
	logic        i_sync_request = 1'h0;
	logic        i_rx_reference_clock = 1'h0;
	wire logic   i_hready;
	wire logic   i_rx_serial;
	wire logic [31:0] o_hrdata;
	wire logic [15:0] o_parallel_data_out;
	wire logic   o_hreadyout, o_hresp, o_tx_serial, o_tx_serial_oe;
	wire logic   o_parallel_data_oe, o_lock_status_n, o_lock_status_oe;
	wire logic   o_recovered_clock, o_recovered_clk_oe;
	int          n_fail = 0;
	int          total_checks = 0;
	int          n;
	logic [31:0] rdata;
	logic [17:0] fr [8];
	logic        fb = 1'h1;
	logic        mute = 1'h0;
	logic        wen = 1'h0;

	always #5 i_clk_sys = ~i_clk_sys;
	// Word clock scaled with the bit clock: 18 bit times per word
	always #90 i_tx_word_clock = wen & ~i_tx_word_clock;
	always #80 i_rx_reference_clock = ~i_rx_reference_clock;
	assign i_hready = o_hreadyout;

	serdes_link uut (.*);
	far_serdes far (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_sync    (fb & o_lock_status_n),
		.i_mute    (mute),
		.i_word    (16'h1234), // Constant word, resends repeat it
		.o_serial  (i_rx_serial)
	);

	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t got %h exp %h", $time, g, e);
		end
	endtask

	task tmo(input int c);
		if (c >= 4000) begin
			n_fail++;
			tally_and_finish;
		end
	endtask

	task skip(input int c);
		repeat (c) @(negedge i_clk_sys);
	endtask

	task wait_ready;
		int c;
		c = 0;
		do begin
			@(posedge i_clk_sys);
			c++;
		end while (i_hready !== 1'h1 && c < 4000);
		tmo(c);
	endtask

	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_hsel <= 1'h1;
		i_haddr <= {24'h0, a};
		i_hwrite <= w;
		i_htrans <= 2'h2;
		wait_ready;
		i_hsel <= 1'h0;
		i_htrans <= 2'h0;
		i_hwdata <= d;
		wait_ready;
		rdata = o_hrdata;
	endtask

	task wait_lock(input logic v);
		for (n = 0; n < 4000 && o_lock_status_n !== v; n++)
			@(negedge i_clk_sys);
		tmo(n);
	endtask

	task t_regs;
		bus(OFS_CTRL, 1'h0, 32'h0);
		chk(rdata, {28'h0, CTRL_RESET});
		bus(OFS_CTRL, 1'h1, 32'hF);
		bus(OFS_CTRL, 1'h0, 32'h0);
		chk(rdata, 32'hF);
		bus(8'h0C, 1'h1, 32'h5);
		bus(8'h0C, 1'h0, 32'h0);
		chk(rdata, 32'h0);
		bus(OFS_CTRL, 1'h1, 32'h7);
		$display("registers done");
	endtask

	task t_tx;
		skip(4);
		chk(o_tx_serial_oe, 32'h0);
		wen = 1'h1;
		skip(120);
		chk(o_tx_serial_oe, 32'h0);
		for (n = 0; n < 4000 && o_tx_serial !== 1'h1; n++)
			@(negedge i_clk_sys);
		tmo(n);
		for (int k = 0; k < 8; k++) begin
			for (int i = 0; i < 18; i++) begin
				fr[k] = {fr[k][16:0], o_tx_serial};
				if (k == 1 && i == 0) begin
					@(posedge i_clk_sys);
					i_sync_request <= 1'h1;
				end
				@(negedge i_clk_sys);
			end
		end
		chk(fr[0], {1'h1, 16'h4B2D, 1'h0});
		chk(fr[6], {1'h1, 16'h4B2D, 1'h0});
		chk(fr[7], {1'h1, SYNC_WORD, 1'h0});
		@(posedge i_clk_sys);
		i_sync_request <= 1'h0;
		bus(OFS_CTRL, 1'h1, 32'h6);
		skip(2);
		chk(o_tx_serial_oe, 32'h0);
		bus(OFS_CTRL, 1'h1, 32'h7);
		skip(2);
		chk(o_tx_serial_oe, 32'h0);
		$display("transmit done");
	endtask

	task t_rx;
		wait_lock(1'h0);
		chk({o_parallel_data_out, o_recovered_clock}, {SYNC_WORD, 1'h1});
		skip(60);
		chk({o_parallel_data_out, o_lock_status_n}, {16'h1234, 1'h0});
		for (n = 0; n < 40 && o_recovered_clock !== 1'h0; n++)
			@(negedge i_clk_sys);
		chk(o_recovered_clock, 32'h0);
		for (n = 0; n < 40 && o_recovered_clock !== 1'h1; n++)
			@(negedge i_clk_sys);
		chk(o_recovered_clock, 32'h1);
		@(posedge i_clk_sys);
		mute <= 1'h1;
		wait_lock(1'h1);
		chk(o_parallel_data_out, 32'h0);
		chk(n >= 45 && n <= 63, 32'h1);
		@(posedge i_clk_sys);
		fb <= 1'h0;
		mute <= 1'h0;
		skip(3600);
		chk(o_lock_status_n, 32'h1);
		bus(OFS_STATUS, 1'h0, 32'h0);
		chk(rdata, 32'h17);
		bus(OFS_CTRL, 1'h1, 32'h3);
		skip(2);
		chk({o_parallel_data_oe, o_lock_status_oe, o_recovered_clk_oe}, 32'h0);
		bus(OFS_CTRL, 1'h1, 32'h5);
		skip(2);
		chk({o_parallel_data_oe, o_lock_status_oe, o_lock_status_n}, 32'h1);
		fb <= 1'h1;
		bus(OFS_CTRL, 1'h1, 32'h7);
		skip(50);
		chk({o_parallel_data_oe, o_lock_status_n}, 32'h1);
		wait_lock(1'h0);
		chk(n >= 2750 && n <= 2850, 32'h1);
		bus(OFS_STATUS, 1'h0, 32'h0);
		chk(rdata, 32'hE);
		bus(OFS_RXDATA, 1'h0, 32'h0);
		chk(rdata, {16'h0, SYNC_WORD});
		$display("receive done");
	endtask

	initial begin
		repeat (6) @(posedge i_clk_sys);
		i_rstn <= 1'h1;
		t_regs;
		t_tx;
		t_rx;
		tally_and_finish;
	end
endmodule
